// ==== hdl/hscfg_top.sv ====
// Sensor channel, sleep, range and axis threshold configuration with crossing logic
// Functional notes
// - Channel codes 0-7 are an axis mask: X=1, Y=2, Z=4
// - Codes 8h, 9h, Ah, Bh run X-Y-X, Y-X-Y, Y-Z-Y, X-Z-X
// - Code Ch converts XYZ with positive offset, Dh with negative offset
// - Code Eh runs resistance plus converter check, Fh offset plus converter
// - Idle field picks sleep time between conversions, wake-and-sleep only
// - Crossing count bit: 0 needs one crossing, 1 needs four
// - Direction bit: 0 above, 1 below; ignored when hysteresis mode above 1
// - Gain target bit picks first or second channel of angle pair
// - Angle field: 0 off, 1 X-Y, 2 Y-Z, 3 X-Z
// - Bit 1 selects X/Y range, 0 is low range and default
// - Bit 0 selects Z range independently
// - X limit is signed code, step is X/Y full scale over 128
// - Y limit is signed code, step is X/Y full scale over 128
// - Z limit is signed code, step follows Z range bit
// - Zero limit code disables comparing and counting for that axis
// - All five registers reset to zero
// - Hysteresis mode 1 uses low seven bits as symmetric magnitude
// - Idle interval only governs timing in operating mode 3
// - Threshold interrupt reaches output only when enabled
`timescale 1ns/10ps
`include "hscfg_cfg.svh"

module hscfg_top #(
  parameter int unsigned MS_CYC = `HSCFG_CYC_PER_MS,
  parameter int unsigned DW     = 8
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          arst_n,
  // Register port
  input  wire logic          reg_wr,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [DW-1:0] reg_wdata,
  output logic      [DW-1:0] reg_rdata,
  // Settings from neighbouring registers
  input  wire logic [1:0]    operating_mode,
  input  wire logic [2:0]    hysteresis_mode,
  input  wire logic          limit_irq_enable,
  // Conversion results, 12-bit signed, one-cycle valid
  input  wire logic          result_vld,
  input  wire logic [1:0]    result_axis,
  input  wire logic [11:0]   result_data,
  // Conversion control
  output logic               conv_start,
  output logic [2:0]         axis_enable,
  output logic [5:0]         axis_sequence,
  output logic               diag_offset_pos,
  output logic               diag_offset_neg,
  output logic               res_check,
  output logic               ofs_check,
  output logic               adc_check,
  // Angle and range
  output logic               angle_enable,
  output logic [1:0]         angle_first,
  output logic [1:0]         angle_second,
  output logic [1:0]         gain_target_axis,
  output logic               xy_range_high,
  output logic               z_range_high,
  // Threshold interrupt
  output logic               limit_irq
);

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] chslp_ff, limcfg_ff;
  logic [7:0] lim_ff [3];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chslp_ff  <= `HSCFG_RST_VAL;
      limcfg_ff <= `HSCFG_RST_VAL;
      lim_ff[0] <= `HSCFG_RST_VAL;
      lim_ff[1] <= `HSCFG_RST_VAL;
      lim_ff[2] <= `HSCFG_RST_VAL;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `HSCFG_OFS_CHSLP:  chslp_ff  <= reg_wdata[7:0];
        // Bit 7 is reserved and stays zero
        `HSCFG_OFS_LIMCFG: limcfg_ff <= reg_wdata[7:0] & `HSCFG_CFG2_WMASK;
        `HSCFG_OFS_XLIM:   lim_ff[0] <= reg_wdata[7:0];
        `HSCFG_OFS_YLIM:   lim_ff[1] <= reg_wdata[7:0];
        `HSCFG_OFS_ZLIM:   lim_ff[2] <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    reg_rdata = '0;
    unique case (reg_addr)
      `HSCFG_OFS_CHSLP:  reg_rdata[7:0] = chslp_ff;
      `HSCFG_OFS_LIMCFG: reg_rdata[7:0] = limcfg_ff;
      `HSCFG_OFS_XLIM:   reg_rdata[7:0] = lim_ff[0];
      `HSCFG_OFS_YLIM:   reg_rdata[7:0] = lim_ff[1];
      `HSCFG_OFS_ZLIM:   reg_rdata[7:0] = lim_ff[2];
      default:           reg_rdata = '0;
    endcase
  end

  logic [3:0] axis_channel_select, idle_interval_select;
  logic       crossing_count_select, limit_direction, gain_target_select;
  logic [1:0] angle_pair;
  assign axis_channel_select   = chslp_ff[`HSCFG_CH_MSB:`HSCFG_CH_LSB];
  assign idle_interval_select  = chslp_ff[`HSCFG_IDLE_MSB:`HSCFG_IDLE_LSB];
  assign crossing_count_select = limcfg_ff[`HSCFG_CNT_BIT];
  assign limit_direction       = limcfg_ff[`HSCFG_DIR_BIT];
  assign gain_target_select    = limcfg_ff[`HSCFG_GAIN_BIT];
  assign angle_pair            = limcfg_ff[`HSCFG_ANG_MSB:`HSCFG_ANG_LSB];

  // ****************************************
  // Channel decode
  // ****************************************
  hscfg_pkg::hscfg_seq_t seq_kind;
  always_comb begin
    axis_enable   = 3'h0;
    axis_sequence = 6'h00;
    seq_kind      = hscfg_pkg::HSCFG_SEQ_MASK;
    unique case (axis_channel_select)
      // Repeated axes, two bits per step, X=1 Y=2 Z=3
      4'h8: begin axis_enable = 3'h3; axis_sequence = {2'h1, 2'h2, 2'h1};
        seq_kind = hscfg_pkg::HSCFG_SEQ_REPEAT; end
      4'h9: begin axis_enable = 3'h3; axis_sequence = {2'h2, 2'h1, 2'h2};
        seq_kind = hscfg_pkg::HSCFG_SEQ_REPEAT; end
      4'hA: begin axis_enable = 3'h6; axis_sequence = {2'h2, 2'h3, 2'h2};
        seq_kind = hscfg_pkg::HSCFG_SEQ_REPEAT; end
      4'hB: begin axis_enable = 3'h5; axis_sequence = {2'h1, 2'h3, 2'h1};
        seq_kind = hscfg_pkg::HSCFG_SEQ_REPEAT; end
      4'hC: begin axis_enable = 3'h7; seq_kind = hscfg_pkg::HSCFG_SEQ_DIAG_POS; end
      4'hD: begin axis_enable = 3'h7; seq_kind = hscfg_pkg::HSCFG_SEQ_DIAG_NEG; end
      4'hE: seq_kind = hscfg_pkg::HSCFG_SEQ_RES_CHK;
      4'hF: seq_kind = hscfg_pkg::HSCFG_SEQ_OFS_CHK;
      default: axis_enable = axis_channel_select[2:0];
    endcase
  end
  assign diag_offset_pos = (seq_kind == hscfg_pkg::HSCFG_SEQ_DIAG_POS);
  assign diag_offset_neg = (seq_kind == hscfg_pkg::HSCFG_SEQ_DIAG_NEG);
  assign res_check       = (seq_kind == hscfg_pkg::HSCFG_SEQ_RES_CHK);
  assign ofs_check       = (seq_kind == hscfg_pkg::HSCFG_SEQ_OFS_CHK);
  assign adc_check       = res_check | ofs_check;

  // ****************************************
  // Angle, gain and range
  // ****************************************
  // Angle pair decode
  always_comb begin
    angle_first  = 2'h0;
    angle_second = 2'h0;
    unique case (angle_pair)
      2'h1: begin angle_first = 2'h1; angle_second = 2'h2; end
      2'h2: begin angle_first = 2'h2; angle_second = 2'h3; end
      2'h3: begin angle_first = 2'h1; angle_second = 2'h3; end
      default: ;
    endcase
  end
  assign angle_enable     = (angle_pair != 2'h0);
  assign gain_target_axis = gain_target_select ? angle_second : angle_first;
  assign xy_range_high    = limcfg_ff[`HSCFG_XYR_BIT];
  assign z_range_high     = limcfg_ff[`HSCFG_ZR_BIT];

  // ****************************************
  // Wake-and-sleep timer
  // ****************************************
  logic [14:0] idle_ms;
  always_comb begin
    unique case (idle_interval_select)
      4'h0: idle_ms = 15'd1;
      4'h1: idle_ms = 15'd5;
      4'h2: idle_ms = 15'd10;
      4'h3: idle_ms = 15'd15;
      4'h4: idle_ms = 15'd20;
      4'h5: idle_ms = 15'd30;
      4'h6: idle_ms = 15'd50;
      4'h7: idle_ms = 15'd100;
      4'h8: idle_ms = 15'd500;
      4'h9: idle_ms = 15'd1000;
      4'hA: idle_ms = 15'd2000;
      4'hB: idle_ms = 15'd500;
      4'hC: idle_ms = 15'd20000;
      default: idle_ms = 15'd20000;
    endcase
  end

  logic        ws_mode;
  logic        ms_tick;
  logic [31:0] ms_div_ff;
  logic [14:0] ms_cnt_ff;
  hscfg_pkg::hscfg_ws_t ws_ff;
  // Only mode 3 runs the idle timer
  assign ws_mode = (operating_mode == `HSCFG_OPMODE_WS);
  assign ms_tick = (ms_div_ff == MS_CYC - 1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) ms_div_ff <= '0;
    else if (!ws_mode || ms_tick || ws_ff != hscfg_pkg::HSCFG_SLEEP) ms_div_ff <= '0;
    else ms_div_ff <= ms_div_ff + 32'd1;
  end

  // Sleep for the selected interval, then convert
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ws_ff     <= hscfg_pkg::HSCFG_IDLE;
      ms_cnt_ff <= '0;
    end else if (!ws_mode) begin
      ws_ff     <= hscfg_pkg::HSCFG_IDLE;
      ms_cnt_ff <= '0;
    end else begin
      unique case (ws_ff)
        hscfg_pkg::HSCFG_IDLE: ws_ff <= hscfg_pkg::HSCFG_SLEEP;
        hscfg_pkg::HSCFG_SLEEP: if (ms_tick) begin
          if (ms_cnt_ff + 15'd1 >= idle_ms) begin
            ms_cnt_ff <= '0;
            ws_ff     <= hscfg_pkg::HSCFG_CONVERT;
          end else ms_cnt_ff <= ms_cnt_ff + 15'd1;
        end
        hscfg_pkg::HSCFG_CONVERT: ws_ff <= hscfg_pkg::HSCFG_SLEEP;
      endcase
    end
  end
  assign conv_start = (ws_ff == hscfg_pkg::HSCFG_CONVERT);

  // ****************************************
  // Threshold crossing
  // ****************************************
  logic [2:0] hit;
  logic [2:0] cross_cnt_ff;
  logic [2:0] need;
  logic       hit_any;

  // Code scaled to 12-bit result: code * 16, range shared
  for (genvar a = 0; a < 3; a++) begin : g_axis
    logic signed [11:0] thr, mag, val;
    logic signed [12:0] thr_abs;
    logic               en;
    assign thr = 12'(signed'(lim_ff[a]) * 16);
    // One bit wider so code 80h still gives a positive magnitude
    assign thr_abs = thr[11] ? -13'(thr) : 13'(thr);
    assign mag = 12'({5'h00, lim_ff[a][6:0]} << 4);
    assign val = signed'(result_data);
    assign en  = (lim_ff[a] != 8'h00) && result_vld && (result_axis == 2'(a + 1))
                 && axis_enable[a];
    always_comb begin
      hit[a] = 1'b0;
      if (en) begin
        if (hysteresis_mode == `HSCFG_HYST_MAG) begin
          // Opposite limit pair, direction picks outside or inside
          if (limit_direction) hit[a] = (val < mag) && (val > -mag);
          else hit[a] = (val > mag) || (val < -mag);
        end else if (hysteresis_mode == `HSCFG_HYST_SIGNED)
          hit[a] = limit_direction ? (val < thr) : (val > thr);
        else
          // Direction ignored in the wider hysteresis modes
          hit[a] = (val > thr_abs) || (val < -thr_abs);
      end
    end
  end
  assign hit_any = |hit;

  assign need = crossing_count_select ? `HSCFG_CROSS_MANY : 3'h1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cross_cnt_ff <= '0;
    else if (hit_any && limit_irq_enable) begin
      if (cross_cnt_ff + 3'h1 >= need) cross_cnt_ff <= '0;
      else cross_cnt_ff <= cross_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) limit_irq <= 1'b0;
    else limit_irq <= hit_any && limit_irq_enable && (cross_cnt_ff + 3'h1 >= need);
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_MASK: assert property (axis_channel_select < 4'h8 |-> axis_enable == axis_channel_select[2:0])
    else $error("Mask mismatch");
  AST_SEQ8: assert property (axis_channel_select == 4'h8 |-> axis_sequence == 6'h19)
    else $error("XYX sequence wrong");
  AST_DIAG: assert property (axis_channel_select == 4'hC |-> diag_offset_pos && axis_enable == 3'h7)
    else $error("Positive diag missing");
  AST_CHK: assert property (axis_channel_select == 4'hF |-> ofs_check && adc_check && !res_check)
    else $error("Offset check wrong");
  AST_NOWS: assert property (!ws_mode |=> !conv_start)
    else $error("Conversion outside wake-and-sleep");
  AST_GAIN: assert property (angle_pair == 2'h2 && gain_target_select |-> gain_target_axis == 2'h3)
    else $error("Gain target wrong");
  AST_ZERO: assert property (lim_ff[0] == 8'h00 && lim_ff[1] == 8'h00 && lim_ff[2] == 8'h00
                             |=> !limit_irq)
    else $error("Irq with zero limits");
  AST_EN: assert property (!limit_irq_enable |=> !limit_irq)
    else $error("Irq while disabled");
  AST_FOUR: assert property (crossing_count_select && $rose(limit_irq) |-> $past(cross_cnt_ff) == 3'h3)
    else $error("Fired before four crossings");
  AST_RANGE: assert property (reg_wr && reg_addr == `HSCFG_OFS_LIMCFG
                              |=> xy_range_high == $past(reg_wdata[1]))
    else $error("Range bit not stored");

  COV_WS: cover property (ws_mode ##1 conv_start);
  COV_IRQ1: cover property (!crossing_count_select && limit_irq);
  COV_IRQ4: cover property (crossing_count_select && limit_irq);
  COV_HYST: cover property (hysteresis_mode == `HSCFG_HYST_MAG && limit_irq);

endmodule : hscfg_top

// ==== hdl/hscfg_cfg.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef HSCFG_CFG_SVH
`define HSCFG_CFG_SVH
`define HSCFG_OFS_CHSLP      8'h02
`define HSCFG_OFS_LIMCFG     8'h03
`define HSCFG_OFS_XLIM       8'h04
`define HSCFG_OFS_YLIM       8'h05
`define HSCFG_OFS_ZLIM       8'h06
`define HSCFG_RST_VAL        8'h00
`define HSCFG_CFG2_WMASK     8'h7F
`define HSCFG_CH_MSB         7
`define HSCFG_CH_LSB         4
`define HSCFG_IDLE_MSB       3
`define HSCFG_IDLE_LSB       0
`define HSCFG_CNT_BIT        6
`define HSCFG_DIR_BIT        5
`define HSCFG_GAIN_BIT       4
`define HSCFG_ANG_MSB        3
`define HSCFG_ANG_LSB        2
`define HSCFG_XYR_BIT        1
`define HSCFG_ZR_BIT         0
`define HSCFG_OPMODE_WS      2'h3
`define HSCFG_HYST_SIGNED    3'h0
`define HSCFG_HYST_MAG       3'h1
`define HSCFG_CROSS_MANY     3'h4
`define HSCFG_CLK_MHZ        100
`define HSCFG_CYC_PER_MS     (`HSCFG_CLK_MHZ * 1000)
`endif

// ==== hdl/hscfg_pkg.sv ====
// Types for the sensor configuration and threshold block
package hscfg_pkg;
  typedef enum logic [1:0] {
    HSCFG_IDLE,
    HSCFG_SLEEP,
    HSCFG_CONVERT
  } hscfg_ws_t;
  typedef enum logic [2:0] {
    HSCFG_SEQ_MASK,
    HSCFG_SEQ_REPEAT,
    HSCFG_SEQ_DIAG_POS,
    HSCFG_SEQ_DIAG_NEG,
    HSCFG_SEQ_RES_CHK,
    HSCFG_SEQ_OFS_CHK
  } hscfg_seq_t;
endpackage : hscfg_pkg

// ==== dv/hscfg_host.sv ====
// Host model: register writes and reads, conversion results
`timescale 1ns/10ps

module hscfg_host (
  // Clock
  input  wire logic        clk,
  // Register port
  output logic             reg_wr,
  output logic [7:0]       reg_addr,
  output logic [7:0]       reg_wdata,
  input  wire logic [7:0]  reg_rdata,
  // Conversion results
  output logic             result_vld,
  output logic [1:0]       result_axis,
  output logic [11:0]      result_data
);
  initial begin
    reg_wr      = 1'b0;
    reg_addr    = 8'hFF;
    reg_wdata   = 8'hA5;
    result_vld  = 1'b0;
    result_axis = 2'h0;
    result_data = 12'h5A5;
  end

  // Released data and axis lines show the inverse so stale values never look valid; reg_addr keeps its value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic res(input logic [1:0] ax, input logic [11:0] d);
    @(posedge clk);
    #1;
    result_vld  = 1'b1;
    result_axis = ax;
    result_data = d;
    @(posedge clk);
    #1;
    result_vld  = 1'b0;
    result_axis = ~ax;
    result_data = ~d;
  endtask : res
endmodule : hscfg_host

// ==== dv/hscfg_top_tb.sv ====
// Self-checking bench for the sensor configuration and threshold block
`timescale 1ns/10ps
`include "hscfg_cfg.svh"

module hscfg_top_tb;
  logic clk = 1'b0, arst_n = 1'b0, reg_wr, result_vld, limit_irq_enable = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [1:0] operating_mode = 2'h0, result_axis, angle_first, angle_second, gain_target_axis;
  logic [2:0] hysteresis_mode = 3'h0, axis_enable;
  logic [11:0] result_data;
  logic [5:0] axis_sequence;
  logic conv_start, diag_offset_pos, diag_offset_neg, res_check, ofs_check, adc_check;
  logic angle_enable, xy_range_high, z_range_high, limit_irq;
  int bad_count = 0, cmp_count = 0, irq_cnt = 0, d0, d1;

  always #5 clk = ~clk;
  always @(posedge clk) if (limit_irq === 1'b1) irq_cnt++;

  hscfg_top #(.MS_CYC(4)) hscfg_top_i (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .operating_mode(operating_mode), .hysteresis_mode(hysteresis_mode),
    .limit_irq_enable(limit_irq_enable), .result_vld(result_vld), .result_axis(result_axis),
    .result_data(result_data), .conv_start(conv_start), .axis_enable(axis_enable),
    .axis_sequence(axis_sequence), .diag_offset_pos(diag_offset_pos),
    .diag_offset_neg(diag_offset_neg), .res_check(res_check), .ofs_check(ofs_check),
    .adc_check(adc_check), .angle_enable(angle_enable), .angle_first(angle_first),
    .angle_second(angle_second), .gain_target_axis(gain_target_axis),
    .xy_range_high(xy_range_high), .z_range_high(z_range_high), .limit_irq(limit_irq));
  hscfg_host hscfg_host_i (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .result_vld(result_vld),
    .result_axis(result_axis), .result_data(result_data));

  // ****************************************
  // Compare and report
  // ****************************************
  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_v

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // One result, then count the pulses it causes
  task automatic hit(input logic [1:0] ax, input logic [11:0] d, input logic [7:0] n);
    irq_cnt = 0;
    hscfg_host_i.res(ax, d);
    repeat (3) @(posedge clk);
    #1;
    chk_v(irq_cnt[7:0], n, "irq pulses");
  endtask : hit

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    for (int a = 2; a <= 7; a++) begin
      hscfg_host_i.rd(a[7:0], rv);
      chk_v(rv, `HSCFG_RST_VAL, "reset value");
    end
    chk_v({axis_enable, angle_enable, xy_range_high, z_range_high, limit_irq, conv_start},
          8'h00, "reset outputs");
    hscfg_host_i.wr(`HSCFG_OFS_LIMCFG, 8'hFF);
    hscfg_host_i.wr(8'h07, 8'hFF);
    hscfg_host_i.rd(`HSCFG_OFS_LIMCFG, rv);
    chk_v(rv, 8'h7F, "reserved bit");
    hscfg_host_i.rd(8'h07, rv);
    chk_v(rv, 8'h00, "unmapped read");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_channel;
    logic [5:0] es;
    for (int c = 0; c < 16; c++) begin
      hscfg_host_i.wr(`HSCFG_OFS_CHSLP, {c[3:0], 4'h0});
      #1;
      es = (c == 8) ? 6'h19 : (c == 9) ? 6'h26 : (c == 10) ? 6'h2E : (c == 11) ? 6'h1D : 6'h00;
      if (c < 8) chk_v({5'h00, axis_enable}, {5'h00, c[2:0]}, "axis mask");
      chk_v({2'b00, axis_sequence}, {2'b00, es}, "sequence");
      chk_v({4'h0, diag_offset_pos, diag_offset_neg, res_check, ofs_check},
            {4'h0, c == 12, c == 13, c == 14, c == 15}, "diag flags");
      chk_v({7'h00, adc_check}, {7'h00, c >= 14}, "converter check");
    end
    $display("t_channel done");
  endtask : t_channel

  task automatic t_angle;
    logic [1:0] f, s;
    for (int a = 0; a < 8; a++) begin
      hscfg_host_i.wr(`HSCFG_OFS_LIMCFG, {3'b100, a[2], a[1:0], a[0], a[1]});
      hscfg_host_i.rd(`HSCFG_OFS_LIMCFG, rv);
      chk_v(rv, {3'b000, a[2], a[1:0], a[0], a[1]}, "config readback");
      f = (a[1:0] == 2) ? 2'h2 : (a[1:0] == 0) ? 2'h0 : 2'h1;
      s = (a[1:0] == 1) ? 2'h2 : (a[1:0] == 0) ? 2'h0 : 2'h3;
      chk_v({angle_enable, angle_first, angle_second, 3'h0},
            {a[1:0] != 0, f, s, 3'h0}, "angle pair");
      chk_v({6'h00, gain_target_axis}, {6'h00, a[2] ? s : f}, "gain target");
      chk_v({6'h00, xy_range_high, z_range_high}, {6'h00, a[0], a[1]}, "ranges");
    end
    $display("t_angle done");
  endtask : t_angle

  task automatic t_limit;
    hscfg_host_i.wr(`HSCFG_OFS_LIMCFG, 8'h00);
    hscfg_host_i.wr(`HSCFG_OFS_CHSLP, 8'h10);
    hit(2'h1, 12'h101, 8'h00);
    hscfg_host_i.wr(`HSCFG_OFS_XLIM, 8'h10);
    hit(2'h1, 12'h101, 8'h00);
    limit_irq_enable = 1'b1;
    hscfg_host_i.res(2'h1, 12'h101);
    chk_v({7'h00, limit_irq}, 8'h01, "irq latency");
    // Let the pulse end before the next count starts
    @(posedge clk);
    #1;
    hit(2'h1, 12'h100, 8'h00);
    hscfg_host_i.wr(`HSCFG_OFS_CHSLP, 8'h70);
    hit(2'h2, 12'h7FF, 8'h00);
    hscfg_host_i.wr(`HSCFG_OFS_CHSLP, 8'h10);
    hscfg_host_i.wr(`HSCFG_OFS_YLIM, 8'h10);
    hit(2'h2, 12'h7FF, 8'h00);
    hscfg_host_i.wr(`HSCFG_OFS_CHSLP, 8'h70);
    hit(2'h2, 12'h101, 8'h01);
    hscfg_host_i.wr(`HSCFG_OFS_ZLIM, 8'h10);
    // Result and limit scale together, so a range change keeps the code threshold
    hscfg_host_i.wr(`HSCFG_OFS_LIMCFG, 8'h01);
    hit(2'h3, 12'h100, 8'h00);
    hit(2'h3, 12'h101, 8'h01);
    hscfg_host_i.wr(`HSCFG_OFS_LIMCFG, 8'h02);
    hit(2'h1, 12'h1FF, 8'h01);
    hscfg_host_i.wr(`HSCFG_OFS_LIMCFG, 8'h20);
    hit(2'h1, 12'h101, 8'h00);
    hit(2'h1, 12'h0FF, 8'h01);
    hscfg_host_i.wr(`HSCFG_OFS_LIMCFG, 8'h40);
    for (int k = 0; k < 3; k++) hit(2'h1, 12'h101, 8'h00);
    hit(2'h1, 12'h101, 8'h01);
    $display("t_limit done");
  endtask : t_limit

  task automatic t_hyst;
    hscfg_host_i.wr(`HSCFG_OFS_LIMCFG, 8'h20);
    hscfg_host_i.wr(`HSCFG_OFS_XLIM, 8'h90);
    hit(2'h1, 12'hEFF, 8'h00);
    hysteresis_mode = `HSCFG_HYST_MAG;
    hit(2'h1, 12'hEFF, 8'h00);
    hit(2'h1, 12'h0FF, 8'h01);
    hscfg_host_i.wr(`HSCFG_OFS_LIMCFG, 8'h00);
    hit(2'h1, 12'hEFF, 8'h01);
    hysteresis_mode = 3'h2;
    hit(2'h1, 12'hEFF, 8'h00);
    hit(2'h1, 12'h8FF, 8'h01);
    hysteresis_mode = `HSCFG_HYST_SIGNED;
    $display("t_hyst done");
  endtask : t_hyst

  // Spacing between two wake-up pulses, in cycles
  task automatic gap(output int n);
    int k;
    k = 0;
    while (conv_start !== 1'b1 && k < 400) begin
      @(posedge clk);
      #1;
      k++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (conv_start !== 1'b1 && n < 400);
  endtask : gap

  task automatic t_sleep;
    hscfg_host_i.wr(`HSCFG_OFS_CHSLP, 8'h10);
    repeat (60) begin
      @(posedge clk);
      #1;
      if (conv_start === 1'b1) chk_v(8'h01, 8'h00, "wake-up outside mode 3");
    end
    operating_mode = `HSCFG_OPMODE_WS;
    gap(d0);
    hscfg_host_i.wr(`HSCFG_OFS_CHSLP, 8'h11);
    gap(d1);
    gap(d1);
    chk_v(d1[7:0] - d0[7:0], 8'h10, "interval 5 ms vs 1 ms");
    operating_mode = 2'h0;
    $display("t_sleep done");
  endtask : t_sleep

  initial begin
    #30_000;
    bad_count++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_channel();
    t_angle();
    t_limit();
    t_hyst();
    t_sleep();
    final_report();
  end
endmodule : hscfg_top_tb
